// [verilog/direct_host_slave_port.sv]
// Purpose: Device end of the direct host slave port with a small internal store.
// Assumes: Host pins arrive from another domain; straps are steady around reset.
// Notes:   Host clock is sampled by sys_clk_i; sync mode acts on its rising edges.
module direct_host_slave_port
    import host_port_pkg::*;
(
    // System
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    // Straps and configuration
    input  wire logic              port_sync_mode_strap_i,
    input  wire logic              port_width_strap_i,
    input  wire logic              port_dual_strobe_i,
    input  wire logic              port_little_endian_i,
    input  wire logic [CID_W-1:0]  device_chip_identity_i,
    // Status
    output logic                   sync_mode_o,
    output logic                   wide_mode_o,
    output logic                   burst_seen_o,
    // Host link
    host_port_if.dev               link
);
    // Two-stage synchronisers for every host pin
    localparam int SW = 2 + ADDR_W + 2 + CID_W + LANES + 4 + 2 + DATA_W;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic          clk_d;
    port_state_t   state;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic          burst_active;
    logic [ADDR_W-1:0] burst_addr;
    logic          strap_taken;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (clk_en_i) begin
            sync1 <= {link.host_chip_select, link.host_broadcast_select, link.host_address,
                      link.host_data_structure, link.host_device_chip_identity_in, link.host_lane_strobe,
                      link.host_read_strobe, link.host_direction_select, link.host_burst_flag,
                      link.host_port_clock, 2'h0, link.host_data_bus};
            sync2 <= sync1;
        end
    end

    wire logic              s_cs    = sync2[SW-1];
    wire logic              s_bcs   = sync2[SW-2];
    wire logic [ADDR_W-1:0] s_addr  = sync2[SW-3 -: ADDR_W];
    wire logic [1:0]        s_dst   = sync2[SW-3-ADDR_W -: 2];
    wire logic [CID_W-1:0]  s_cid   = sync2[SW-5-ADDR_W -: CID_W];
    wire logic [LANES-1:0]  s_lane  = sync2[SW-5-ADDR_W-CID_W -: LANES];
    wire logic              s_rds   = sync2[DATA_W+5];
    wire logic              s_dir   = sync2[DATA_W+4];
    wire logic              s_burst = sync2[DATA_W+3];
    wire logic              s_hclk  = sync2[DATA_W+2];
    wire logic [DATA_W-1:0] s_data  = sync2[DATA_W-1:0];

    // Straps caught by a clocked process at reset release
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            strap_taken <= 1'b0;
            sync_mode_o <= 1'b0;
            wide_mode_o <= 1'b0;
        end else if (clk_en_i && !strap_taken) begin
            strap_taken <= 1'b1;
            sync_mode_o <= port_sync_mode_strap_i;
            wide_mode_o <= port_width_strap_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            clk_d <= 1'b0;
        end else if (clk_en_i) begin
            clk_d <= s_hclk;
        end
    end

    // Sync mode samples only on host clock rising edges
    wire logic hclk_rise = s_hclk && !clk_d;
    wire logic tick      = sync_mode_o ? hclk_rise : 1'b1;

    wire logic id_hit  = s_cs && (s_cid == device_chip_identity_i);
    wire logic sel_any = id_hit || s_bcs;

    // Lane qualifiers per mode
    wire logic any_lane = |s_lane;
    wire logic is_read  = port_dual_strobe_i ? s_rds : (any_lane && s_dir);
    wire logic is_write = port_dual_strobe_i ? any_lane : (any_lane && !s_dir);
    wire logic rd_ok    = id_hit && is_read;
    wire logic wr_ok    = sel_any && is_write;
    wire logic use_burst = sync_mode_o && s_burst;
    wire logic [ADDR_W-1:0] eff_addr = burst_active ? burst_addr : s_addr;

    // Little-endian byte arrangement
    function automatic logic [DATA_W-1:0] arrange(input logic [DATA_W-1:0] d,
                                                  input logic [1:0] dst,
                                                  input logic le);
        logic [DATA_W-1:0] r;
        r = d;
        if (le) begin
            case (dst)
                DST_HALF: r = {d[15:0], d[31:16]};
                DST_SWAP: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
                DST_BYTE: r = d;
                default:  r = d;
            endcase
        end
        return r;
    endfunction

    wire logic [DATA_W-1:0] wr_word = arrange(s_data, s_dst, port_little_endian_i);
    wire logic [LANES-1:0]  wr_lanes = wide_mode_o ? s_lane : {2'h0, s_lane[1:0]};

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state                  <= ST_IDLE;
            link.host_transfer_ack <= 1'b0;
            link.dev_data_oe       <= 1'b0;
            link.dev_data_out      <= '0;
            burst_active           <= 1'b0;
            burst_addr             <= '0;
            burst_seen_o           <= 1'b0;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (clk_en_i) begin
            case (state)
                ST_IDLE: begin
                    if (tick && wr_ok) begin
                        state <= ST_WRITE;
                    end else if (tick && rd_ok) begin
                        link.dev_data_out <= arrange(mem[eff_addr], s_dst,
                                                     port_little_endian_i);
                        link.dev_data_oe  <= 1'b1;
                        state             <= ST_READ;
                    end
                end
                ST_WRITE: begin
                    for (int l = 0; l < LANES; l++) begin
                        if (wr_lanes[l]) begin
                            mem[eff_addr][8*l +: 8] <= wr_word[8*l +: 8];
                        end
                    end
                    link.host_transfer_ack <= 1'b1;
                    state                  <= ST_ACK;
                end
                ST_READ: begin
                    link.host_transfer_ack <= 1'b1;
                    state                  <= ST_ACK;
                end
                ST_ACK: begin
                    // Burst steps the address once, as the acknowledge ends
                    if (sync_mode_o) begin
                        if (tick) begin
                            burst_active <= use_burst;
                            if (use_burst) begin
                                burst_seen_o <= 1'b1;
                                burst_addr   <= eff_addr + 2'h1;
                            end
                            link.host_transfer_ack <= 1'b0;
                            link.dev_data_oe       <= 1'b0;
                            state                  <= ST_IDLE;
                        end
                    end else begin
                        burst_active <= 1'b0;
                        state        <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!is_read && !is_write) begin
                        link.host_transfer_ack <= 1'b0;
                        link.dev_data_oe       <= 1'b0;
                        state                  <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // direct_host_slave_port

// [verilog/host_port_pkg.sv]
// Purpose: Shared constants and types for the direct host slave port.
// Assumes: Both ends run on sys_clk_i at 100 MHz.
// Notes:   Lane count, widths and mode encodings live here only.
package host_port_pkg;
    localparam int          LANES        = 4;
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 2;
    localparam int          CID_W        = 4;
    localparam int          MEM_DEPTH    = 4;
    localparam logic [3:0]  DEVICE_CHIP_IDENTITY_RST  = 4'h5;   // Arbitrary identity value
    localparam logic [1:0]  DST_WORD     = 2'h0;
    localparam logic [1:0]  DST_HALF     = 2'h1;
    localparam logic [1:0]  DST_BYTE     = 2'h2;
    localparam logic [1:0]  DST_SWAP     = 2'h3;
    localparam int          LINK_DIV     = 4;     // Host clock half period in sys clocks
    localparam logic [2:0]  LINK_DIV_MAX = 3'(LINK_DIV - 1);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WRITE = 3'b001,
        ST_READ  = 3'b010,
        ST_ACK   = 3'b011,
        ST_WAIT  = 3'b100
    } port_state_t;
endpackage

// [verilog/host_port_if.sv]
// Purpose: Pins between the host and the direct slave port.
// Assumes: Data bus resolved here from the two enables.
// Notes:   Strobes, selects and the acknowledge are active high on this carrier.
interface host_port_if;
    import host_port_pkg::*;
    logic [ADDR_W-1:0] host_address;
    logic              host_chip_select;
    logic              host_broadcast_select;
    logic [CID_W-1:0]  host_device_chip_identity_in;
    logic [LANES-1:0]  host_lane_strobe;
    logic              host_read_strobe;
    logic              host_direction_select;
    logic              host_burst_flag;
    logic [1:0]        host_data_structure;
    logic              host_port_clock;
    logic              host_transfer_ack;
    logic [DATA_W-1:0] host_data_out;
    logic              host_data_oe;
    logic [DATA_W-1:0] dev_data_out;
    logic              dev_data_oe;
    logic [DATA_W-1:0] host_data_bus;

    assign host_data_bus = dev_data_oe ? dev_data_out :
                           (host_data_oe ? host_data_out : '0);

    modport host (
        output host_address, host_chip_select, host_broadcast_select, host_device_chip_identity_in,
        output host_lane_strobe, host_read_strobe, host_direction_select,
        output host_burst_flag, host_data_structure, host_port_clock,
        output host_data_out, host_data_oe,
        input  host_transfer_ack, host_data_bus
    );
    modport dev (
        input  host_address, host_chip_select, host_broadcast_select, host_device_chip_identity_in,
        input  host_lane_strobe, host_read_strobe, host_direction_select,
        input  host_burst_flag, host_data_structure, host_port_clock, host_data_bus,
        output host_transfer_ack, dev_data_out, dev_data_oe
    );
endinterface

// [verilog/host_port_master.sv]
// Purpose: Host end that drives the direct slave port from a user command port.
// Assumes: Acknowledge arrives from another domain and is synchronised.
// Notes:   Host clock made by a divider of sys_clk_i.
module host_port_master
    import host_port_pkg::*;
(
    // System
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    // Mode
    input  wire logic              dual_strobe_i,
    // Command
    input  wire logic              cmd_valid_i,
    input  wire logic              cmd_write_i,
    input  wire logic              cmd_broadcast_i,
    input  wire logic              cmd_burst_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [CID_W-1:0]  cmd_device_chip_identity_i,
    input  wire logic [LANES-1:0]  cmd_lanes_i,
    input  wire logic [1:0]        cmd_structure_i,
    input  wire logic [DATA_W-1:0] cmd_wdata_i,
    // Answer
    output logic                   busy_o,
    output logic                   done_o,
    output logic [DATA_W-1:0]      rdata_o,
    // Link
    host_port_if.host              link
);
    logic        ack_s1;
    logic        ack_s2;
    logic [2:0]  div_cnt;
    logic        writing;
    logic [DATA_W-1:0] rd_s1;
    port_state_t state;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            rd_s1  <= '0;
        end else if (clk_en_i) begin
            ack_s1 <= link.host_transfer_ack;
            ack_s2 <= ack_s1;
            rd_s1  <= link.host_data_bus;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            div_cnt              <= '0;
            link.host_port_clock <= 1'b0;
        end else if (clk_en_i) begin
            if (div_cnt == LINK_DIV_MAX) begin
                div_cnt              <= '0;
                link.host_port_clock <= ~link.host_port_clock;
            end else begin
                div_cnt <= div_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state                      <= ST_IDLE;
            writing                    <= 1'b0;
            busy_o                     <= 1'b0;
            done_o                     <= 1'b0;
            rdata_o                    <= '0;
            link.host_address          <= '0;
            link.host_chip_select      <= 1'b0;
            link.host_broadcast_select <= 1'b0;
            link.host_device_chip_identity_in       <= '0;
            link.host_lane_strobe      <= '0;
            link.host_read_strobe      <= 1'b0;
            link.host_direction_select <= 1'b0;
            link.host_burst_flag       <= 1'b0;
            link.host_data_structure   <= '0;
            link.host_data_out         <= '0;
            link.host_data_oe          <= 1'b0;
        end else if (clk_en_i) begin
            done_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cmd_valid_i) begin
                        writing                    <= cmd_write_i;
                        busy_o                     <= 1'b1;
                        link.host_address          <= cmd_addr_i;
                        link.host_device_chip_identity_in       <= cmd_device_chip_identity_i;
                        link.host_chip_select      <= !cmd_broadcast_i;
                        link.host_broadcast_select <= cmd_broadcast_i;
                        link.host_burst_flag       <= cmd_burst_i;
                        link.host_data_structure   <= cmd_structure_i;
                        link.host_direction_select <= !cmd_write_i;
                        link.host_data_out         <= cmd_wdata_i;
                        link.host_data_oe          <= cmd_write_i;
                        state                      <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Setup cycle before strobes
                    if (dual_strobe_i && !writing) begin
                        link.host_read_strobe <= 1'b1;
                    end else begin
                        link.host_lane_strobe <= cmd_lanes_i;
                    end
                    state <= writing ? ST_WRITE : ST_READ;
                end
                ST_WRITE, ST_READ: begin
                    if (ack_s2) begin
                        rdata_o               <= rd_s1;
                        link.host_lane_strobe <= '0;
                        link.host_read_strobe <= 1'b0;
                        state                 <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (!ack_s2) begin
                        link.host_chip_select      <= 1'b0;
                        link.host_broadcast_select <= 1'b0;
                        link.host_burst_flag       <= 1'b0;
                        link.host_data_oe          <= 1'b0;
                        busy_o                     <= 1'b0;
                        done_o                     <= 1'b1;
                        state                      <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // host_port_master

// [dv/direct_host_slave_port_assertions.sv]
// Purpose: Link checks between host master and slave port.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Instantiated beside the interface in the bench.
module direct_host_slave_port_assertions
    import host_port_pkg::*;
#(
    parameter logic [CID_W-1:0] DEVICE_CHIP_IDENTITY = DEVICE_CHIP_IDENTITY_RST
) (
    // System
    input wire logic              sys_clk_i,
    input wire logic              rst_n_i,
    // Link
    input wire logic              host_chip_select,
    input wire logic              host_broadcast_select,
    input wire logic [CID_W-1:0]  host_device_chip_identity_in,
    input wire logic [LANES-1:0]  host_lane_strobe,
    input wire logic              host_read_strobe,
    input wire logic              host_port_clock,
    input wire logic              host_transfer_ack,
    input wire logic              host_data_oe,
    input wire logic [DATA_W-1:0] dev_data_out,
    input wire logic              dev_data_oe
);
    logic any_strobe;
    assign any_strobe = (|host_lane_strobe) || host_read_strobe;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence ack_up_s;
        $rose(host_transfer_ack);
    endsequence
    sequence strobes_idle_s;
        !any_strobe [*4];
    endsequence
    id_match_a: assert property (ack_up_s |-> host_broadcast_select ||
        (host_chip_select && host_device_chip_identity_in == DEVICE_CHIP_IDENTITY)) else $error("ack without selection");
    read_select_a: assert property ($rose(dev_data_oe) |->
        host_chip_select && !host_data_oe) else $error("read data without select");
    data_valid_a: assert property (ack_up_s and dev_data_oe |->
        $past(dev_data_oe)) else $error("read ack before data");
    data_stable_a: assert property (host_transfer_ack && $past(host_transfer_ack)
        && dev_data_oe |-> $stable(dev_data_out)) else $error("read data moved");
    ack_strobe_a: assert property (ack_up_s |-> any_strobe)
        else $error("ack without strobe");
    sync_delay_a: assert property (ack_up_s |-> $past(any_strobe, 2))
        else $error("ack too early");
    ack_release_a: assert property (strobes_idle_s |-> ##[0:12] !host_transfer_ack)
        else $error("ack held after strobes");
    link_clock_a: assert property ($rose(host_port_clock) |->
        host_port_clock [*4] ##1 !host_port_clock) else $error("host clock period");
endmodule // direct_host_slave_port_assertions

// [dv/direct_host_slave_port_tb.sv]
// Purpose: Both ends joined; scenarios drive the master command port.
// Assumes: Straps and modes changed only under reset.
// Notes:   Refused accesses end with a reset, as the master then waits.
module direct_host_slave_port_tb
    import host_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              sys_clk_i = 1'b0;
    logic              rst_n_i   = 1'b0;
    logic [3:0]        mode      = 4'h2;
    logic              cmd_valid = 1'b0;
    logic              cmd_write = 1'b0;
    logic              cmd_bcast = 1'b0;
    logic              cmd_burst = 1'b0;
    logic [ADDR_W-1:0] cmd_addr  = '0;
    logic [CID_W-1:0]  cmd_id    = '0;
    logic [LANES-1:0]  cmd_lanes = '0;
    logic [1:0]        cmd_st    = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic              busy_o, done_o, sync_mode_o, wide_mode_o, burst_seen_o;
    logic [DATA_W-1:0] rdata_o;
    logic [DATA_W-1:0] old;
    int                error_cnt = 0;
    int                checks    = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    host_port_if link_if ();
    direct_host_slave_port u_direct_host_slave_port (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
        .port_sync_mode_strap_i(mode[3]), .port_width_strap_i(mode[2]),
        .port_dual_strobe_i(mode[1]), .port_little_endian_i(mode[0]),
        .device_chip_identity_i(DEVICE_CHIP_IDENTITY_RST), .sync_mode_o(sync_mode_o),
        .wide_mode_o(wide_mode_o), .burst_seen_o(burst_seen_o), .link(link_if.dev));
    host_port_master u_host_port_master (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .dual_strobe_i(mode[1]),
        .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_broadcast_i(cmd_bcast),
        .cmd_burst_i(cmd_burst), .cmd_addr_i(cmd_addr), .cmd_device_chip_identity_i(cmd_id),
        .cmd_lanes_i(cmd_lanes), .cmd_structure_i(cmd_st), .cmd_wdata_i(cmd_wdata),
        .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .link(link_if.host));
    direct_host_slave_port_assertions u_direct_host_slave_port_assertions (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .host_chip_select(link_if.host_chip_select),
        .host_broadcast_select(link_if.host_broadcast_select),
        .host_device_chip_identity_in(link_if.host_device_chip_identity_in), .host_lane_strobe(link_if.host_lane_strobe),
        .host_read_strobe(link_if.host_read_strobe), .host_port_clock(link_if.host_port_clock),
        .host_transfer_ack(link_if.host_transfer_ack), .host_data_oe(link_if.host_data_oe),
        .dev_data_out(link_if.dev_data_out), .dev_data_oe(link_if.dev_data_oe));

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic restart(input logic [3:0] m);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        mode    <= m;
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
    endtask

    // One command; ok tells whether done_o came back
    task automatic xfer(input logic wr, input logic bc, input logic bu,
                        input logic [ADDR_W-1:0] a, input logic [CID_W-1:0] id,
                        input logic [LANES-1:0] ln, input logic [1:0] st,
                        input logic [DATA_W-1:0] wd, input logic exp_ok);
        logic ok;
        @(posedge sys_clk_i);
        cmd_valid <= 1'b1;
        {cmd_write, cmd_bcast, cmd_burst, cmd_addr} <= {wr, bc, bu, a};
        {cmd_id, cmd_lanes, cmd_st, cmd_wdata} <= {id, ln, st, wd};
        @(posedge sys_clk_i);
        cmd_valid <= 1'b0;
        ok = 1'b0;
        for (int i = 0; i < 150 && !ok; i++) begin
            @(negedge sys_clk_i);
            ok = (done_o === 1'b1);
        end
        check({31'h0, ok}, {31'h0, exp_ok});
        check({31'h0, busy_o}, {31'h0, ~exp_ok});
    endtask

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
                                                input logic [DATA_W-1:0] n,
                                                input logic [LANES-1:0] ln);
        for (int l = 0; l < LANES; l++) begin
            if (ln[l]) o[8*l +: 8] = n[8*l +: 8];
        end
        return o;
    endfunction

    // Full words on every address, then lane subsets
    task automatic t_lanes(input logic [3:0] m);
        logic [DATA_W-1:0] d;
        restart(m);
        for (int a = 0; a < MEM_DEPTH; a++) begin
            d = 32'hC0DE_0000 + 32'(a * 32'h0101);
            xfer(1'b1, 1'b0, 1'b0, 2'(a), DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, d, 1'b1);
            xfer(1'b0, 1'b0, 1'b0, 2'(a), DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
            check(rdata_o, d);
        end
        for (int l = 1; l < 16; l += 3) begin
            old = merge(32'hC0DE_0101, {4{8'(l)}}, 4'(l));
            xfer(1'b1, 1'b0, 1'b0, 2'h1, DEVICE_CHIP_IDENTITY_RST, 4'(l), DST_WORD, {4{8'(l)}}, 1'b1);
            xfer(1'b0, 1'b0, 1'b0, 2'h1, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
            check(rdata_o, old);
            xfer(1'b1, 1'b0, 1'b0, 2'h1, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, 32'hC0DE_0101, 1'b1);
        end
    endtask

    task automatic t_select();
        restart(4'h6);
        xfer(1'b0, 1'b0, 1'b0, 2'h0, DEVICE_CHIP_IDENTITY_RST ^ 4'h1, 4'hF, DST_WORD, '0, 1'b0);
        restart(4'h6);
        xfer(1'b1, 1'b1, 1'b0, 2'h2, DEVICE_CHIP_IDENTITY_RST ^ 4'h3, 4'hF, DST_WORD, 32'h0BCA_57ED, 1'b1);
        xfer(1'b0, 1'b0, 1'b0, 2'h2, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
        check(rdata_o, 32'h0BCA_57ED);
        xfer(1'b0, 1'b1, 1'b0, 2'h2, DEVICE_CHIP_IDENTITY_RST ^ 4'h3, 4'hF, DST_WORD, '0, 1'b0);
    endtask

    task automatic t_modes();
        restart(4'hE);
        check({31'h0, sync_mode_o}, 32'h1);
        check({31'h0, wide_mode_o}, 32'h1);
        xfer(1'b1, 1'b0, 1'b1, 2'h0, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, 32'h5A5A_0001, 1'b1);
        check({31'h0, burst_seen_o}, 32'h1);
        // Beat after a burst lands on the next word
        xfer(1'b1, 1'b0, 1'b0, 2'h0, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, 32'h5A5A_0003, 1'b1);
        xfer(1'b0, 1'b0, 1'b0, 2'h1, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
        check(rdata_o, 32'h5A5A_0003);
        xfer(1'b0, 1'b0, 1'b0, 2'h0, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
        check(rdata_o, 32'h5A5A_0001);
        restart(4'h6);
        check({31'h0, sync_mode_o}, 32'h0);
        xfer(1'b1, 1'b0, 1'b1, 2'h0, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, 32'h5A5A_0002, 1'b1);
        check({31'h0, burst_seen_o}, 32'h0);
        xfer(1'b1, 1'b0, 1'b0, 2'h0, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, 32'h5A5A_0004, 1'b1);
        xfer(1'b0, 1'b0, 1'b0, 2'h0, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
        check(rdata_o, 32'h5A5A_0004);
        restart(4'h2);
        check({31'h0, wide_mode_o}, 32'h0);
        xfer(1'b0, 1'b0, 1'b0, 2'h3, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
        old = rdata_o;
        xfer(1'b1, 1'b0, 1'b0, 2'h3, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, 32'hFEED_BEEF, 1'b1);
        xfer(1'b0, 1'b0, 1'b0, 2'h3, DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
        check(rdata_o, {old[31:16], 16'hBEEF});
    endtask

    task automatic t_endian();
        logic [1:0]        st [3]  = '{DST_SWAP, DST_HALF, DST_BYTE};
        logic [DATA_W-1:0] exp [3] = '{32'h4433_2211, 32'h3344_1122, 32'h1122_3344};
        restart(4'h7);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, 1'b0, 1'b0, 2'(i), DEVICE_CHIP_IDENTITY_RST, 4'hF, st[i], 32'h1122_3344, 1'b1);
            xfer(1'b0, 1'b0, 1'b0, 2'(i), DEVICE_CHIP_IDENTITY_RST, 4'hF, DST_WORD, '0, 1'b1);
            check(rdata_o, exp[i]);
            xfer(1'b0, 1'b0, 1'b0, 2'(i), DEVICE_CHIP_IDENTITY_RST, 4'hF, st[i], '0, 1'b1);
            check(rdata_o, 32'h1122_3344);
        end
    endtask

    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end

    initial begin
        t_lanes(4'h6);
        t_lanes(4'h4);
        t_lanes(4'hE);
        t_lanes(4'hC);
        t_select();
        t_modes();
        t_endian();
        complete_run();
    end
endmodule // direct_host_slave_port_tb
